// file: rtl/jtdl_consts.vh
// Constants for the scan-to-bus debug link
`ifndef JTDL_CONSTS_VH
`define JTDL_CONSTS_VH
`define JTDL_IR_W          4
`define JTDL_IR_CMD        4'h2
`define JTDL_IR_DATA       4'h3
`define JTDL_IR_IDCODE     4'h1
`define JTDL_IR_BYPASS     4'hf
`define JTDL_IR_RESET      4'h1
`define JTDL_CMD_W         35
`define JTDL_CMD_DIR_BIT   34
`define JTDL_CMD_SIZE_HI   33
`define JTDL_CMD_SIZE_LO   32
`define JTDL_DATA_W        33
`define JTDL_DATA_SEQ_BIT  32
`define JTDL_SIZE_BYTE     2'h0
`define JTDL_SIZE_HALF     2'h1
`define JTDL_SIZE_WORD     2'h2
`define JTDL_DIR_READ      1'h0
`define JTDL_DIR_WRITE     1'h1
`define JTDL_HTRANS_IDLE   2'h0
`define JTDL_HTRANS_NONSEQ 2'h2
`define JTDL_ADDR_STEP     32'h0000_0004
`define JTDL_IDCODE_VALUE  32'h1234_5671
`define JTDL_FIFO_DEPTH    16
`define JTDL_FIFO_AW       4
`endif

// file: rtl/jtdl_fifo.v
// Parameterised valid/ready FIFO for bus requests
`default_nettype none
module jtdl_fifo #(
  parameter WIDTH = 67,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wptr;
  reg [AW:0]      rptr;
  wire            full;
  wire            empty;
  assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty     = (wptr == rptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rptr[AW-1:0]];
  always @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule // jtdl_fifo
`default_nettype wire

// file: rtl/jtdl_link.v
// Scan-to-bus debug link: TAP, scan registers and bus master
// Operation
// - Two instructions select command/address and data scan registers.
// - Command register: 35 bits, direction top, size next two, address low 32.
// - Direction zero reads, one writes.
// - Size 00 byte, 01 half-word, 10 word; 11 reserved.
// - Read command update starts bus read; result shifts out of data register.
// - Write: command first, then data scan carries write data.
// - Data register: 33 bits, sequential flag on top, data low 32.
// - Sequential flag set in data scan advances address by one word.
// - Sequential transfers always use word size.
// - Byte and half-word data placed big-endian in data field.
// - Block masters the system bus, reading or writing any address.
// - Instruction codes are build parameters, defaults 2 and 3.
// - Crossing synchronisers are one or two stages, chosen at build.
`include "jtdl_consts.vh"
`default_nettype none
module jtdl_link #(
  parameter [`JTDL_IR_W-1:0] CMD_INST  = `JTDL_IR_CMD,
  parameter [`JTDL_IR_W-1:0] DATA_INST = `JTDL_IR_DATA,
  parameter                  NSYNC     = 2,
  parameter [31:0]           IDCODE    = `JTDL_IDCODE_VALUE // Arbitrary value
) (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg  [31:0] haddr,
  output reg  [1:0]  htrans,
  output reg         hwrite,
  output reg  [2:0]  hsize,
  output reg  [2:0]  hburst,
  output reg  [31:0] hwdata,
  output reg         hbusreq,
  input  wire        hgrant,
  input  wire        hready,
  input  wire [1:0]  hresp,
  input  wire [31:0] hrdata,
  output wire        busy
);
  localparam S_RESET = 4'd0, S_IDLE = 4'd1, S_DRSEL = 4'd2, S_DRCAP = 4'd3;
  localparam S_DRSH = 4'd4, S_DREX1 = 4'd5, S_DRPA = 4'd6, S_DREX2 = 4'd7;
  localparam S_DRUP = 4'd8, S_IRSEL = 4'd9, S_IRCAP = 4'd10, S_IRSH = 4'd11;
  localparam S_IREX1 = 4'd12, S_IRPA = 4'd13, S_IREX2 = 4'd14, S_IRUP = 4'd15;
  localparam B_IDLE = 2'd0, B_REQ = 2'd1, B_ADDR = 2'd2, B_DATA = 2'd3;

  // Big-endian lane placement for narrow transfers
  function [31:0] jtdl_lane;
    input [31:0] d;
    input [1:0]  sz;
    input [1:0]  off;
    input        to_bus;
    begin
      jtdl_lane = d;
      if (sz == `JTDL_SIZE_BYTE) begin
        if (to_bus) jtdl_lane = {4{d[31:24]}};
        else jtdl_lane = {d >> ((3 - off) * 8)} << 24;
      end else if (sz == `JTDL_SIZE_HALF) begin
        if (to_bus) jtdl_lane = {2{d[31:16]}};
        else jtdl_lane = {(off[1] ? d[15:0] : d[31:16]), 16'h0000};
      end
    end
  endfunction

  // Pin synchronisers: with NSYNC of 2 the first stage feeds only the next stage; with NSYNC of 1 it drives the logic directly
  reg  [1:0] s_tck, s_tms, s_tdi;
  wire       tck_v = (NSYNC == 1) ? s_tck[0] : s_tck[1];
  wire       tms_v = (NSYNC == 1) ? s_tms[0] : s_tms[1];
  wire       tdi_v = (NSYNC == 1) ? s_tdi[0] : s_tdi[1];
  reg        tck_d;
  wire       tck_rise = tck_v && !tck_d;
  wire       tck_fall = !tck_v && tck_d;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_tck <= 2'b00;
      s_tms <= 2'b11;
      s_tdi <= 2'b00;
      tck_d <= 1'b0;
    end else begin
      s_tck <= {s_tck[0], tck};
      s_tms <= {s_tms[0], tms};
      s_tdi <= {s_tdi[0], tdi};
      tck_d <= tck_v;
    end
  end

  reg [3:0]            tap;
  reg [3:0]            next_tap;
  reg [`JTDL_IR_W-1:0] ir_sh, ir;
  reg [34:0]           cmd_sh;
  reg [32:0]           dat_sh;
  reg [31:0]           id_sh;
  reg                  byp;
  reg [34:0]           cmd;
  reg [31:0]           rdata;
  reg                  rd_pending;
  wire                 sel_cmd = (ir == CMD_INST);
  wire                 sel_dat = (ir == DATA_INST);
  wire                 sel_id  = (ir == `JTDL_IR_IDCODE);
  wire                 fifo_ready;
  reg                  fifo_push;
  reg  [66:0]          fifo_in;

  always @* begin
    next_tap = tap;
    case (tap)
      S_RESET: next_tap = tms_v ? S_RESET : S_IDLE;
      S_IDLE:  next_tap = tms_v ? S_DRSEL : S_IDLE;
      S_DRSEL: next_tap = tms_v ? S_IRSEL : S_DRCAP;
      S_DRCAP: next_tap = tms_v ? S_DREX1 : S_DRSH;
      S_DRSH:  next_tap = tms_v ? S_DREX1 : S_DRSH;
      S_DREX1: next_tap = tms_v ? S_DRUP : S_DRPA;
      S_DRPA:  next_tap = tms_v ? S_DREX2 : S_DRPA;
      S_DREX2: next_tap = tms_v ? S_DRUP : S_DRSH;
      S_DRUP:  next_tap = tms_v ? S_DRSEL : S_IDLE;
      S_IRSEL: next_tap = tms_v ? S_RESET : S_IRCAP;
      S_IRCAP: next_tap = tms_v ? S_IREX1 : S_IRSH;
      S_IRSH:  next_tap = tms_v ? S_IREX1 : S_IRSH;
      S_IREX1: next_tap = tms_v ? S_IRUP : S_IRPA;
      S_IRPA:  next_tap = tms_v ? S_IREX2 : S_IRPA;
      S_IREX2: next_tap = tms_v ? S_IRUP : S_IRSH;
      S_IRUP:  next_tap = tms_v ? S_DRSEL : S_IDLE;
      default: next_tap = S_RESET;
    endcase
  end

  // Request word: write flag, size, address, data
  wire [1:0] seq_size = `JTDL_SIZE_WORD;
  always @* begin
    fifo_push = 1'b0;
    fifo_in   = {cmd[34:0], dat_sh[31:0]};
    if (tck_rise && tap == S_DRUP && fifo_ready) begin
      if (sel_cmd && cmd_sh[`JTDL_CMD_DIR_BIT] == `JTDL_DIR_READ) begin
        fifo_push = 1'b1;
        fifo_in   = {cmd_sh, 32'h0000_0000};
      end else if (sel_dat && cmd[`JTDL_CMD_DIR_BIT] == `JTDL_DIR_WRITE) begin
        fifo_push = 1'b1;
        fifo_in   = {cmd, dat_sh[31:0]};
      end
    end
  end

  // Step from the aligned word: a word access at an odd address is illegal on the bus
  wire [31:0] next_addr = {cmd[31:2], 2'b00} + `JTDL_ADDR_STEP;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tap    <= S_RESET;
      ir     <= `JTDL_IR_RESET;
      ir_sh  <= {`JTDL_IR_W{1'b0}};
      cmd_sh <= {35{1'b0}};
      dat_sh <= {33{1'b0}};
      id_sh  <= 32'h0000_0000;
      byp    <= 1'b0;
      cmd    <= {35{1'b0}};
      tdo    <= 1'b0;
    end else begin
      if (tck_rise) begin
        tap <= next_tap;
        case (tap)
          S_RESET: ir <= `JTDL_IR_RESET;
          S_IRCAP: ir_sh <= {{(`JTDL_IR_W-1){1'b0}}, 1'b1};
          S_IRSH:  ir_sh <= {tdi_v, ir_sh[`JTDL_IR_W-1:1]};
          S_IRUP:  ir <= ir_sh;
          S_DRCAP: begin
            cmd_sh <= cmd;
            dat_sh <= {1'b0, rdata};
            id_sh  <= IDCODE;
            byp    <= 1'b0;
          end
          S_DRSH: begin
            if (sel_cmd) cmd_sh <= {tdi_v, cmd_sh[34:1]};
            else if (sel_dat) dat_sh <= {tdi_v, dat_sh[32:1]};
            else if (sel_id) id_sh <= {tdi_v, id_sh[31:1]};
            else byp <= tdi_v;
          end
          S_DRUP: begin
            if (sel_cmd) begin
              cmd <= cmd_sh;
            end else if (sel_dat && dat_sh[`JTDL_DATA_SEQ_BIT]) begin
              // Next access: next word, word size, same direction
              cmd <= {cmd[`JTDL_CMD_DIR_BIT], seq_size, next_addr};
            end
          end
          default: ;
        endcase
      end
      if (tck_fall) begin
        if (tap == S_IRSH) tdo <= ir_sh[0];
        else if (tap == S_DRSH) begin
          if (sel_cmd) tdo <= cmd_sh[0];
          else if (sel_dat) tdo <= dat_sh[0];
          else if (sel_id) tdo <= id_sh[0];
          else tdo <= byp;
        end
      end
    end
  end

  // Sequential reads prefetch the next word at data update
  reg seq_rd;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) seq_rd <= 1'b0;
    else seq_rd <= tck_rise && tap == S_DRUP && sel_dat && dat_sh[`JTDL_DATA_SEQ_BIT] &&
                   cmd[`JTDL_CMD_DIR_BIT] == `JTDL_DIR_READ;
  end

  wire        q_valid;
  reg         q_ready;
  wire [66:0] q_data;
  // Prefetch shares the queue; read-command and write-data scan pushes win the slot
  wire        push_any = fifo_push || (seq_rd && fifo_ready);
  wire [66:0] push_word = fifo_push ? fifo_in : {cmd, 32'h0000_0000};
  jtdl_fifo #(
    .WIDTH (67),
    .DEPTH (`JTDL_FIFO_DEPTH),
    .AW    (`JTDL_FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (push_any),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // Bus master
  reg [1:0]  bst;
  reg [66:0] cur;
  always @* begin
    q_ready = (bst == B_IDLE);
  end
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bst        <= B_IDLE;
      cur        <= {67{1'b0}};
      haddr      <= 32'h0000_0000;
      htrans     <= `JTDL_HTRANS_IDLE;
      hwrite     <= 1'b0;
      hsize      <= 3'h0;
      hburst     <= 3'h0;
      hwdata     <= 32'h0000_0000;
      hbusreq    <= 1'b0;
      rdata      <= 32'h0000_0000;
      rd_pending <= 1'b0;
    end else begin
      case (bst)
        B_IDLE: if (q_valid) begin
          cur        <= q_data;
          hbusreq    <= 1'b1;
          rd_pending <= 1'b1;
          bst        <= B_REQ;
        end else rd_pending <= 1'b0;
        B_REQ: if (hgrant && hready) begin
          haddr   <= cur[63:32];
          hwrite  <= cur[66];
          hsize   <= {1'b0, cur[65:64]};
          htrans  <= `JTDL_HTRANS_NONSEQ;
          hbusreq <= 1'b0;
          bst     <= B_ADDR;
        end
        B_ADDR: if (hready) begin
          htrans <= `JTDL_HTRANS_IDLE;
          hwdata <= jtdl_lane(cur[31:0], cur[65:64], cur[33:32], 1'b1);
          bst    <= B_DATA;
        end
        B_DATA: if (hready) begin
          if (!cur[66]) rdata <= jtdl_lane(hrdata, cur[65:64], cur[33:32], 1'b0);
          bst <= B_IDLE;
        end
        default: bst <= B_IDLE;
      endcase
    end
  end
  assign busy = (bst != B_IDLE) || q_valid || rd_pending;
endmodule // jtdl_link
`default_nettype wire

// file: bench/jtdl_link_assertions.sv
// Bus-side assertions for the scan-to-bus debug link
`include "jtdl_consts.vh"
`default_nettype none
module jtdl_link_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [2:0]  hburst,
  input wire logic [31:0] hwdata,
  input wire logic        hbusreq,
  input wire logic        hgrant,
  input wire logic        hready,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_addr;
    htrans == `JTDL_HTRANS_NONSEQ && hready;
  endsequence
  sequence s_wdata;
    s_addr ##0 hwrite ##1 !hready;
  endsequence
  property p_req_hold; hbusreq && !hgrant |=> hbusreq; endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request dropped before grant");
  property p_granted; $rose(htrans == `JTDL_HTRANS_NONSEQ) |-> $past(hgrant); endproperty
  a_granted: assert property (p_granted) else $error("address phase without grant");
  property p_single; s_addr |=> htrans == `JTDL_HTRANS_IDLE; endproperty
  a_single: assert property (p_single) else $error("transfer not single");
  property p_addr_hold;
    htrans == `JTDL_HTRANS_NONSEQ && !hready |=> htrans == `JTDL_HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address phase changed in wait");
  property p_wdata; s_wdata |=> $stable(hwdata); endproperty
  a_wdata: assert property (p_wdata) else $error("write data changed in wait");
  property p_size; htrans == `JTDL_HTRANS_NONSEQ |-> hsize <= 3'h2; endproperty
  a_size: assert property (p_size) else $error("illegal transfer size");
  property p_burst; htrans == `JTDL_HTRANS_NONSEQ |-> hburst == 3'h0; endproperty
  a_burst: assert property (p_burst) else $error("transfer not a single burst");
  property p_busy; htrans != `JTDL_HTRANS_IDLE || hbusreq |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("bus activity while not busy");
  property p_start;
    $rose(hgrant) && hbusreq && hready |-> ##[1:2] htrans == `JTDL_HTRANS_NONSEQ;
  endproperty
  a_start: assert property (p_start) else $error("no address phase after grant");
endmodule // jtdl_link_chk
bind jtdl_link jtdl_link_chk jtdl_link_chk_i (.mclk(mclk), .rstn(rstn), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hwdata(hwdata), .hbusreq(hbusreq), .hgrant(hgrant),
  .hready(hready), .busy(busy));
`default_nettype wire

// file: bench/jtdl_ahb_slave.sv
// Bus slave memory and arbiter model facing the debug link
`default_nettype none
module jtdl_ahb_slave (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hbusreq,
  input  wire logic        slow,
  input  wire logic        stall,
  output var logic         hgrant,
  output logic             hready,
  output logic [31:0]      hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:63];
  logic [31:0] a;
  logic [2:0]  sz;
  logic        dph;
  logic        wr;
  logic        waited;
  int          ntx;
  // When slow, the first address cycle also stalls, as a foreign data phase would
  assign hready = !(slow && !waited && (dph || htrans == 2'h2));
  // Outside a read data phase the bus shows junk, not stale data
  assign hrdata = (dph && !wr && hready) ? mem[a[7:2]] : ~mem[a[7:2]];
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dph <= 1'b0;
      waited <= 1'b0;
      hgrant <= 1'b0;
      ntx <= 0;
      for (int i = 0; i < 64; i++) mem[i] <= 32'h0000_0000;
    end else begin
      hgrant <= hbusreq && !stall;
      waited <= !hready;
      if (hready) begin
        for (int b = 0; b < 4; b++) begin
          if (dph && wr && (sz == 3'h2 || (sz == 3'h1 && b[1] == a[1]) || b == a[1:0]))
            mem[a[7:2]][31-8*b -: 8] <= hwdata[31-8*b -: 8];
        end
        dph <= htrans == 2'h2;
        a <= haddr;
        wr <= hwrite;
        sz <= hsize;
        ntx <= ntx + int'(htrans == 2'h2);
      end
    end
  end
endmodule // jtdl_ahb_slave
`default_nettype wire

// file: bench/jtdl_link_tb.sv
// Self-checking bench: scans through the TAP drive bus transfers
`include "jtdl_consts.vh"
`default_nettype none
module jtdl_link_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0;
  logic        rstn = 0;
  logic        tck = 0;
  logic        tms = 1;
  logic        tdi = 0;
  logic        slow = 0;
  logic        stall = 0;
  wire         tdo, hwrite, hbusreq, hgrant, hready, busy;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize, hburst;
  int          fail_count = 0;
  int          checks_done = 0;
  int          n0;
  logic [63:0] got, res;
  always #2.5 mclk = ~mclk;
  jtdl_link jtdl_link_i (.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hwdata(hwdata), .hbusreq(hbusreq),
    .hgrant(hgrant), .hready(hready), .hresp(2'h0), .hrdata(hrdata), .busy(busy));
  jtdl_ahb_slave jtdl_ahb_slave_i (.mclk(mclk), .rstn(rstn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hbusreq(hbusreq), .slow(slow), .stall(stall), .hgrant(hgrant),
    .hready(hready), .hrdata(hrdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Link clock is free of the system clock, so edges land anywhere
  task automatic clk1(input logic m, input logic d);
    tms = m;
    tdi = d;
    #24 tck = 1;
    got = {tdo, got[63:1]};
    #24 tck = 0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [63:0] v);
    clk1(1, 0);
    if (ir) clk1(1, 0);
    clk1(0, 0);
    clk1(0, 0);
    for (int i = 0; i < n; i++) clk1(i == n - 1, v[i]);
    res = got >> (64 - n);
    clk1(1, 0);
    clk1(0, 0);
  endtask
  task automatic idle;
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k > 400) begin
        fail_count++;
        conclude;
      end
      @(negedge mclk);
    end
  endtask
  // Command scan, then data scan; reads leave their result in res
  task automatic op(input logic [34:0] c, input logic [32:0] d);
    scan(1, 4, 2);
    scan(0, 35, c);
    idle;
    scan(1, 4, 3);
    scan(0, 33, d);
    idle;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rstn = 1;
    repeat (3) @(negedge mclk);
    chk({hburst, busy, hbusreq, htrans}, 0);
    repeat (5) clk1(1, 0);
    clk1(0, 0);
    // Reset leaves the identity instruction selected
    scan(0, 32, 0);
    chk(res[31:0], `JTDL_IDCODE_VALUE);
    scan(1, 4, 4'hf);
    chk(res[3:0], 4'h1);
    // Bypass delays the scan path by one stage
    scan(0, 8, 8'h5A);
    chk(res[7:0], 8'hB4);
    @(negedge mclk) slow = 1;
    op({1'b1, 2'h2, 32'h0000_0010}, {1'b1, 32'h0000_00A0});
    for (int i = 1; i < 3; i++) begin
      scan(0, 33, {i < 2, 32'h0000_00A0 + i});
      idle;
    end
    for (int i = 0; i < 3; i++) chk(jtdl_ahb_slave_i.mem[4+i], 32'h0000_00A0 + i);
    op({1'b0, 2'h2, 32'h0000_0014}, {1'b1, 32'h0000_0000});
    chk(res[31:0], 32'h0000_00A1);
    scan(0, 33, 0);
    chk(res[31:0], 32'h0000_00A2);
    @(negedge mclk) slow = 0;
    op({1'b1, 2'h0, 32'h0000_0021}, {1'b0, 32'hAB00_0000});
    op({1'b1, 2'h1, 32'h0000_0022}, {1'b0, 32'hCDEF_0000});
    chk(jtdl_ahb_slave_i.mem[8], 32'h00AB_CDEF);
    op({1'b0, 2'h0, 32'h0000_0021}, 0);
    chk(res[31:24], 8'hAB);
    op({1'b0, 2'h1, 32'h0000_0022}, 0);
    chk(res[31:16], 16'hCDEF);
    op({1'b1, 2'h0, 32'h0000_0030}, {1'b1, 32'h1122_3344});
    scan(0, 33, {1'b0, 32'h5566_7788});
    idle;
    chk(jtdl_ahb_slave_i.mem[12], 32'h1100_0000);
    chk(jtdl_ahb_slave_i.mem[13], 32'h5566_7788);
    // One request waits in the master, sixteen queue, the last is dropped
    @(negedge mclk) stall = 1;
    n0 = jtdl_ahb_slave_i.ntx;
    scan(1, 4, 2);
    repeat (18) scan(0, 35, {1'b0, 2'h2, 32'h0000_0000});
    @(negedge mclk) stall = 0;
    idle;
    chk(jtdl_ahb_slave_i.ntx - n0, 17);
    conclude;
  end
endmodule // jtdl_link_tb
`default_nettype wire
